// file: design/asc_pkg.sv
// Shared constants and types for the serial command and conversion control block.
// Assumes one 125 MHz core clock; the analog core supplies results on the same clock.
package asc_pkg;
	// Geometry
	localparam int NUM_CH   = 8;
	localparam int RES_BITS = 14;

	// Command byte layout
	localparam int          BIT_START  = 7;
	localparam int          CHAN_HI    = 6;
	localparam int          CHAN_LO    = 4;
	localparam logic [3:0]  START_TAIL = 4'h0;
	localparam logic [3:0]  MODE_TAIL  = 4'h8;

	// Conversion method / power codes
	localparam logic [2:0] MODE_XCLK  = 3'h0;
	localparam logic [2:0] MODE_XACQ  = 3'h1;
	localparam logic [2:0] MODE_INT   = 3'h2;
	localparam logic [2:0] MODE_RSV3  = 3'h3;
	localparam logic [2:0] MODE_RESET = 3'h4;
	localparam logic [2:0] MODE_RSV5  = 3'h5;
	localparam logic [2:0] MODE_PPD   = 3'h6;
	localparam logic [2:0] MODE_FPD   = 3'h7;
	localparam logic [2:0] MODE_RST_VAL = MODE_XCLK;

	// Range codes
	localparam logic [2:0] RNG_NONE   = 3'h0;
	localparam logic [2:0] RNG_SE_BQ  = 3'h1;
	localparam logic [2:0] RNG_SE_NH  = 3'h2;
	localparam logic [2:0] RNG_SE_PH  = 3'h3;
	localparam logic [2:0] RNG_SE_BH  = 3'h4;
	localparam logic [2:0] RNG_SE_N1  = 3'h5;
	localparam logic [2:0] RNG_SE_P1  = 3'h6;
	localparam logic [2:0] RNG_BIP_HI = 3'h7;
	localparam logic [2:0] RNG_DF_1   = 3'h1;
	localparam logic [2:0] RNG_DF_2   = 3'h4;
	localparam logic [2:0] RNG_DF_4   = 3'h7;

	// Full-scale span in reference units
	localparam logic [1:0] SPAN_HALF = 2'h0;
	localparam logic [1:0] SPAN_ONE  = 2'h1;
	localparam logic [1:0] SPAN_TWO  = 2'h2;
	localparam logic [1:0] SPAN_FOUR = 2'h3;

	// Sampling points and start-bit thresholds (remaining result bits)
	localparam logic [4:0] XCLK_SAMPLE_FALL = 5'h0E;
	localparam logic [4:0] XACQ_SAMPLE_FALL = 5'h10;
	localparam logic [4:0] INT_START_FALL   = 5'h08;
	localparam logic [4:0] BYTE_LAST_BIT    = 5'h07;
	localparam logic [4:0] RES_LOAD         = 5'h0E;
	localparam logic [4:0] LEFT_XCLK        = 5'h01;
	localparam logic [4:0] LEFT_XACQ        = 5'h05;
	localparam logic [4:0] LEFT_INT         = 5'h02;

	// Internal conversion clock timing
	localparam int         CORE_CLK_NS     = 8;
	localparam int         INT_CLK_NS      = 222;
	localparam int         INT_CLK_CYC     = INT_CLK_NS / CORE_CLK_NS;
	localparam int         SAMPLE_INT_CLKS = 11;
	localparam int         CONV_INT_CLKS   = 16;
	localparam logic [11:0] SAMPLE_CYC     = 12'(SAMPLE_INT_CLKS * INT_CLK_CYC);
	localparam logic [11:0] XACQ_END_CYC   = 12'(CONV_INT_CLKS * INT_CLK_CYC);
	localparam logic [11:0] INT_END_CYC    = 12'((SAMPLE_INT_CLKS + CONV_INT_CLKS) * INT_CLK_CYC);

	// Per-channel configuration
	typedef struct packed {
		logic       diff_single_select;
		logic [2:0] range;
	} asc_cfg_t;
	localparam asc_cfg_t CFG_RST_VAL = '{diff_single_select: 1'b0, range: RNG_BIP_HI};

	// Serial pins from the master
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} asc_link_in_t;

	// Setup of the conversion in flight
	typedef struct packed {
		logic [2:0] chan;
		asc_cfg_t   cfg;
		logic [1:0] full_scale_span;
		logic       bipolar;
	} asc_conv_t;

	typedef enum logic [5:0] {
		PH_IDLE = 6'h01,
		PH_XCLK = 6'h02,
		PH_XACQ = 6'h04,
		PH_INTW = 6'h08,
		PH_CONV = 6'h10,
		PH_DONE = 6'h20
	} asc_phase_t;

	typedef struct packed {
		logic                                cs_m;
		logic                                cs_s;
		logic                                sclk_m;
		logic                                sclk_s;
		logic                                sclk_p;
		logic                                din_m;
		logic                                din_s;
		logic [3:0]                          in_cnt;
		logic [7:0]                          in_sh;
		logic [2:0]                          mode;
		logic [NUM_CH-1:0][3:0]              cfg;
		asc_phase_t                          phase;
		logic [4:0]                          fall_cnt;
		logic [11:0]                         tmr;
		logic [RES_BITS-1:0]                 res_sh;
		logic [4:0]                          out_left;
		logic                                dout;
		logic                                dout_oe;
		logic                                strobe;
		logic                                sample;
		asc_conv_t                           conv;
	} asc_state_t;
endpackage

// file: design/asc_top.sv
// Serial command decoder and conversion sequencer of a 14-bit multirange converter.
// Assumes pins come straight from the master (asynchronous) and the analog core
// hands its result on i_conv_result in the core clock domain.
`timescale 1ns/1ns

// Function
// - Single-ended configs decode to bipolar or unipolar half, one or two spans.
// - Differential codes 001, 100, 111 give one, two, four spans; others reserved.
// - Each analog input keeps its own diff/single choice and range.
// - A command starts at the first high input bit while chip select low.
// - Idle: start accepted when no conversion runs and all result bits left.
// - External clock mode: start accepted once bits thirteen to one left.
// - External acquisition mode: start accepted once bits thirteen to five left.
// - Internal clock mode: start accepted once bits thirteen to two left.
// - Result leaves in offset binary, top bit first; later bits change on falling clock, internal modes set the top bit at conversion end.
// - Results are fourteen bits wide.
// - One three-bit mode register, set by a mode command byte, selects method and power state.
// - External clock mode: serial clock runs conversion; sample at fourteenth fall.
// - External clock mode: done strobe stays low.
// - External acquisition: serial clock sets capture, internal clock converts.
// - Internal clock mode: own clock samples and converts without serial clocks.
// - Select low: sample input on rise, drive output on fall; else float.
// - Mode codes: 0,1,2 methods, 4 reset, 6 partial, 7 full down.
// - Reset code restores external clock mode and default channel configs.
module asc_top (
	input  wire logic                              i_core_clk,
	input  wire logic                              i_srst,
	input  wire asc_pkg::asc_link_in_t             i_link,
	input  wire logic [asc_pkg::RES_BITS-1:0]      i_conv_result,
	output logic                                   o_dout,
	output logic                                   o_dout_oe,
	output logic                                   o_conversion_done_strobe,
	output logic                                   o_sample_pulse,
	output logic [2:0]                             o_mode,
	output asc_pkg::asc_conv_t                     o_conv
);

	// Accepts a configuration nibble unless it is a reserved code
	function automatic logic cfg_ok(input logic [3:0] c);
		logic ok;
		ok = 1'b0;
		if (c[3]) begin
			ok = (c[2:0] == asc_pkg::RNG_DF_1) || (c[2:0] == asc_pkg::RNG_DF_2) ||
			     (c[2:0] == asc_pkg::RNG_DF_4);
		end else begin
			ok = (c[2:0] != asc_pkg::RNG_NONE);
		end
		return ok;
	endfunction

	// True for the three conversion methods, false for power-down codes
	function automatic logic is_method(input logic [2:0] m);
		logic r;
		r = (m == asc_pkg::MODE_XCLK) || (m == asc_pkg::MODE_XACQ) || (m == asc_pkg::MODE_INT);
		return r;
	endfunction

	// Span and polarity of a stored configuration
	function automatic logic [2:0] span_of(input logic [3:0] c);
		logic [2:0] r;
		r = {asc_pkg::SPAN_TWO, 1'b1};
		if (c[3]) begin
			case (c[2:0])
				asc_pkg::RNG_DF_1: r = {asc_pkg::SPAN_ONE, 1'b1};
				asc_pkg::RNG_DF_2: r = {asc_pkg::SPAN_TWO, 1'b1};
				default:           r = {asc_pkg::SPAN_FOUR, 1'b1};
			endcase
		end else begin
			case (c[2:0])
				asc_pkg::RNG_SE_BQ: r = {asc_pkg::SPAN_HALF, 1'b1};
				asc_pkg::RNG_SE_NH: r = {asc_pkg::SPAN_HALF, 1'b0};
				asc_pkg::RNG_SE_PH: r = {asc_pkg::SPAN_HALF, 1'b0};
				asc_pkg::RNG_SE_BH: r = {asc_pkg::SPAN_ONE, 1'b1};
				asc_pkg::RNG_SE_N1: r = {asc_pkg::SPAN_ONE, 1'b0};
				asc_pkg::RNG_SE_P1: r = {asc_pkg::SPAN_ONE, 1'b0};
				default:            r = {asc_pkg::SPAN_TWO, 1'b1};
			endcase
		end
		return r;
	endfunction

	asc_pkg::asc_state_t s_r;
	asc_pkg::asc_state_t s_nxt;

	// Next-state logic
	always_comb begin
		logic       rise;
		logic       fall;
		logic       sel;
		logic       ok;
		logic [7:0] b;
		logic [4:0] cnt_n;
		logic [2:0] sp;
		rise  = 1'b0;
		fall  = 1'b0;
		sel   = 1'b0;
		ok    = 1'b0;
		b     = 8'h00;
		cnt_n = 5'h00;
		sp    = 3'h0;
		s_nxt = s_r;
		s_nxt.sample = 1'b0;

		// Two-flop synchronisers, then edge detection on the second flop
		s_nxt.cs_m   = i_link.cs_n;
		s_nxt.cs_s   = s_r.cs_m;
		s_nxt.sclk_m = i_link.sclk;
		s_nxt.sclk_s = s_r.sclk_m;
		s_nxt.sclk_p = s_r.sclk_s;
		s_nxt.din_m  = i_link.din;
		s_nxt.din_s  = s_r.din_m;
		sel  = ~s_r.cs_s;
		rise = sel & s_r.sclk_s & ~s_r.sclk_p;
		fall = sel & ~s_r.sclk_s & s_r.sclk_p;
		s_nxt.dout_oe = sel;

		// Start-bit qualification per phase and method
		case (s_r.phase)
			asc_pkg::PH_IDLE: ok = (s_r.out_left == 5'h00);
			asc_pkg::PH_XCLK: ok = (s_r.fall_cnt >= asc_pkg::XCLK_SAMPLE_FALL) &&
			                       (s_r.out_left <= asc_pkg::LEFT_XCLK);
			asc_pkg::PH_DONE: begin
				if (s_r.mode == asc_pkg::MODE_XACQ) begin
					ok = (s_r.out_left <= asc_pkg::LEFT_XACQ);
				end else begin
					ok = (s_r.out_left <= asc_pkg::LEFT_INT);
				end
			end
			default: ok = 1'b0;
		endcase

		// Chip select high drops any partial byte
		if (!sel) begin
			s_nxt.in_cnt = 4'h0;
		end

		// Command byte capture on rising serial clock
		if (rise) begin
			if (s_r.in_cnt == 4'h0) begin
				if (s_r.din_s && ok) begin
					s_nxt.in_cnt   = 4'h1;
					s_nxt.in_sh    = 8'h01;
					s_nxt.strobe   = 1'b0;
					s_nxt.fall_cnt = 5'h00;
					s_nxt.out_left = 5'h00;
					s_nxt.phase    = asc_pkg::PH_IDLE;
				end
			end else begin
				s_nxt.in_sh  = {s_r.in_sh[6:0], s_r.din_s};
				s_nxt.in_cnt = s_r.in_cnt + 4'h1;
				if ({1'b0, s_r.in_cnt} == asc_pkg::BYTE_LAST_BIT) begin
					b = {s_r.in_sh[6:0], s_r.din_s};
					s_nxt.in_cnt = 4'h0;
					if (b[3:0] == asc_pkg::START_TAIL) begin
						// Conversion start; setup kept while powered down
						sp = span_of(s_r.cfg[b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO]]);
						if (is_method(s_r.mode)) begin
							s_nxt.conv.chan            = b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO];
							s_nxt.conv.cfg             = s_r.cfg[b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO]];
							s_nxt.conv.full_scale_span = sp[2:1];
							s_nxt.conv.bipolar         = sp[0];
						end
						case (s_r.mode)
							asc_pkg::MODE_XCLK: s_nxt.phase = asc_pkg::PH_XCLK;
							asc_pkg::MODE_XACQ: s_nxt.phase = asc_pkg::PH_XACQ;
							asc_pkg::MODE_INT:  s_nxt.phase = asc_pkg::PH_INTW;
							default:            s_nxt.phase = asc_pkg::PH_IDLE;
						endcase
					end else if (b[3:0] == asc_pkg::MODE_TAIL) begin
						case (b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO])
							asc_pkg::MODE_RESET: begin
								s_nxt.mode = asc_pkg::MODE_RST_VAL;
								for (int i = 0; i < asc_pkg::NUM_CH; i++) begin
									s_nxt.cfg[i] = asc_pkg::CFG_RST_VAL;
								end
							end
							asc_pkg::MODE_RSV3: s_nxt.mode = s_r.mode;
							asc_pkg::MODE_RSV5: s_nxt.mode = s_r.mode;
							default: s_nxt.mode = b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO];
						endcase
					end else if (cfg_ok(b[3:0])) begin
						s_nxt.cfg[b[asc_pkg::CHAN_HI:asc_pkg::CHAN_LO]] = b[3:0];
					end
				end
			end
		end

		// Falling serial clock: count, shift result, sampling points
		if (fall) begin
			cnt_n = (s_r.fall_cnt == 5'h1F) ? s_r.fall_cnt : s_r.fall_cnt + 5'h01;
			s_nxt.fall_cnt = cnt_n;
			if (s_r.out_left != 5'h00) begin
				s_nxt.res_sh   = {s_r.res_sh[asc_pkg::RES_BITS-2:0], 1'b0};
				s_nxt.dout     = s_r.res_sh[asc_pkg::RES_BITS-2];
				s_nxt.out_left = s_r.out_left - 5'h01;
				if (s_r.out_left == 5'h01) begin
					s_nxt.phase = asc_pkg::PH_IDLE;
				end
			end
			case (s_r.phase)
				asc_pkg::PH_XCLK: begin
					if (cnt_n == asc_pkg::XCLK_SAMPLE_FALL) begin
						s_nxt.sample   = 1'b1;
						s_nxt.res_sh   = i_conv_result;
						s_nxt.dout     = i_conv_result[asc_pkg::RES_BITS-1];
						s_nxt.out_left = asc_pkg::RES_LOAD;
					end
				end
				asc_pkg::PH_XACQ: begin
					if (cnt_n == asc_pkg::XACQ_SAMPLE_FALL) begin
						s_nxt.sample = 1'b1;
						s_nxt.phase  = asc_pkg::PH_CONV;
						s_nxt.tmr    = 12'h000;
					end
				end
				asc_pkg::PH_INTW: begin
					if (cnt_n == asc_pkg::INT_START_FALL) begin
						s_nxt.phase = asc_pkg::PH_CONV;
						s_nxt.tmr   = 12'h000;
					end
				end
				default: s_nxt.tmr = s_r.tmr;
			endcase
		end

		// Internal conversion clock timing, no serial clocks needed
		if (s_r.phase == asc_pkg::PH_CONV) begin
			s_nxt.tmr = s_r.tmr + 12'h001;
			if (s_r.mode == asc_pkg::MODE_INT && s_r.tmr == asc_pkg::SAMPLE_CYC - 12'h001) begin
				s_nxt.sample = 1'b1;
			end
			if ((s_r.mode == asc_pkg::MODE_XACQ && s_r.tmr == asc_pkg::XACQ_END_CYC - 12'h001) ||
			    (s_r.mode != asc_pkg::MODE_XACQ && s_r.tmr == asc_pkg::INT_END_CYC - 12'h001)) begin
				s_nxt.phase    = asc_pkg::PH_DONE;
				s_nxt.res_sh   = i_conv_result;
				s_nxt.dout     = i_conv_result[asc_pkg::RES_BITS-1];
				s_nxt.out_left = asc_pkg::RES_LOAD;
				s_nxt.strobe   = 1'b1;
			end
		end

		// Done strobe never rises in external clock mode
		if (s_r.mode == asc_pkg::MODE_XCLK) begin
			s_nxt.strobe = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s_r        <= '0;
			s_r.cs_m   <= 1'b1;
			s_r.cs_s   <= 1'b1;
			s_r.phase  <= asc_pkg::PH_IDLE;
			s_r.mode   <= asc_pkg::MODE_RST_VAL;
			s_r.cfg    <= {asc_pkg::NUM_CH{asc_pkg::CFG_RST_VAL}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign o_dout                   = s_r.dout;
	assign o_dout_oe                = s_r.dout_oe;
	assign o_conversion_done_strobe = s_r.strobe;
	assign o_sample_pulse           = s_r.sample;
	assign o_mode                   = s_r.mode;
	assign o_conv                   = s_r.conv;

endmodule // asc_top

// file: tb/asc_master.sv
// Behavioural serial master that frames command bytes and reads result words.
// Assumes an 8 ns core clock: four cycles make one 32 ns link half period.
`timescale 1ns/1ns
module asc_master (
	input  wire logic             i_clk,
	input  wire logic             i_dout,
	output asc_pkg::asc_link_in_t o_link,
	output logic [15:0]           o_rx
);
	// Idle pins: select high, clock parked low
	initial begin
		o_link = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
		o_rx = 16'h0000;
	end
	// One link half period
	task automatic half();
		repeat (4) @(posedge i_clk);
	endtask
	// Command MSB first, optional second command from clock at2, zero fill, capture before each fall
	task automatic frame(input logic [7:0] cmd, input int nclk, input logic [7:0] cmd2, input int at2);
		o_link.cs_n <= 1'b0;
		half();
		for (int i = 0; i < nclk; i++) begin
			if (i < 8) begin
				o_link.din <= cmd[7-i];
			end else if (i >= at2 && i < at2 + 8) begin
				o_link.din <= cmd2[7-(i-at2)];
			end else begin
				o_link.din <= 1'b0;
			end
			half();
			o_link.sclk <= 1'b1;
			half();
			o_rx <= {o_rx[14:0], i_dout};
			o_link.sclk <= 1'b0;
		end
		half();
		// Release select; released data line shows the inverse
		o_link.cs_n <= 1'b1;
		o_link.din <= ~o_link.din;
		half();
	endtask
endmodule // asc_master

// file: tb/asc_top_properties.sv
// Concurrent checks on the serial command and conversion control block.
// Assumes it is bound to asc_top and sees only that module's ports.
`timescale 1ns/1ns
module asc_top_properties (
	input wire logic                         i_core_clk,
	input wire logic                         i_srst,
	input wire asc_pkg::asc_link_in_t        i_link,
	input wire logic [asc_pkg::RES_BITS-1:0] i_conv_result,
	input wire logic                         o_dout,
	input wire logic                         o_dout_oe,
	input wire logic                         o_conversion_done_strobe,
	input wire logic                         o_sample_pulse,
	input wire logic [2:0]                   o_mode,
	input wire asc_pkg::asc_conv_t           o_conv
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	// Strobe and pin enable
	AST_STROBE_XCLK: assert property (o_mode == 3'h0 |-> !o_conversion_done_strobe)
		else $error("strobe high in external clock mode");
	AST_OE_OFF: assert property (i_link.cs_n [*5] |-> !o_dout_oe)
		else $error("data pin driven while deselected");
	AST_OE_ON: assert property ((!i_link.cs_n) [*5] |-> o_dout_oe)
		else $error("data pin not driven while selected");
	// Driven data out moves only while the serial clock is low
	AST_DOUT_FALL: assert property ($changed(o_dout) && o_dout_oe && $past(o_dout_oe)
		|-> !$past(i_link.sclk, 2)) else $error("data out changed off a falling clock");
	AST_SAMPLE_ONE: assert property (o_sample_pulse |=> !o_sample_pulse)
		else $error("sample pulse longer than one cycle");
	AST_SAMPLE_FALL: assert property (o_sample_pulse && o_mode != 3'h2 |-> !$past(i_link.sclk, 2))
		else $error("serial sample not on a falling clock");
	AST_STROBE_CLEAR: assert property ($fell(o_conversion_done_strobe)
		|-> $past(i_link.sclk, 2) && !i_link.cs_n) else $error("strobe cleared off a start bit");
	AST_MODE_LEGAL: assert property (!(o_mode inside {3'h3, 3'h4, 3'h5}))
		else $error("mode holds a reserved or reset code");
	AST_MODE_BYTE: assert property ($changed(o_mode) |-> $past(i_link.sclk, 2) && !i_link.cs_n)
		else $error("mode changed outside a byte");
	AST_CONV_BYTE: assert property ($changed(o_conv) |-> $past(i_link.sclk, 2) && !i_link.cs_n)
		else $error("conversion setup changed outside a byte");
	// Main scenarios
	cover property (o_sample_pulse && o_mode == 3'h2);
	cover property ($rose(o_conversion_done_strobe));
	cover property (o_mode == 3'h6);
endmodule // asc_top_properties

bind asc_top asc_top_properties u_props (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_link(i_link),
	.i_conv_result(i_conv_result), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
	.o_conversion_done_strobe(o_conversion_done_strobe), .o_sample_pulse(o_sample_pulse),
	.o_mode(o_mode), .o_conv(o_conv));

// file: tb/test_asc_top.sv
// Self-checking bench: commands through the serial master, checks setup and words.
// Assumes asc_master as far side and the bound property checker.
`timescale 1ns/1ns
module test_asc_top;
	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	logic [13:0]           res = 14'h2C5A;
	asc_pkg::asc_link_in_t link;
	logic                  dout, oe, strb, smp, pin;
	logic [2:0]            mode;
	asc_pkg::asc_conv_t    conv;
	logic [15:0]           rx;
	int                    n_errors = 0;
	int                    tests_run = 0;
	always #4 clk = ~clk;
	// Released data pin shows the inverse of its last value
	assign pin = oe ? dout : ~dout;
	asc_master u_m (.i_clk(clk), .i_dout(pin), .o_link(link), .o_rx(rx));
	asc_top DUT (.i_core_clk(clk), .i_srst(srst), .i_link(link), .i_conv_result(res), .o_dout(dout),
		.o_dout_oe(oe), .o_conversion_done_strobe(strb), .o_sample_pulse(smp), .o_mode(mode), .o_conv(conv));
	// Expected setup: span and polarity from the range tables
	function automatic logic [9:0] expc(input logic [2:0] ch, input logic d, input logic [2:0] r);
		logic [1:0] sp;
		sp = d ? ((r == 3'h1) ? 2'h1 : (r == 3'h4) ? 2'h2 : 2'h3) : ((r == 3'h7) ? 2'h2 : (r > 3'h3) ? 2'h1 : 2'h0);
		return {ch, d, r, sp, d | (r == 3'h1) | (r == 3'h4) | (r == 3'h7)};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// External clock conversion with a full 28-clock read
	task automatic start0(input logic [9:0] e);
		u_m.frame({1'b1, e[9:7], 4'h0}, 28, 8'h00, 0);
		chk(16'(conv), 16'(e));
		chk(16'(rx[13:0]), 16'(res));
	endtask
	// Internal conversion: start, wait for strobe, two read bytes
	task automatic convi(input int nclk, input logic [9:0] e);
		u_m.frame({1'b1, e[9:7], 4'h0}, nclk, 8'h00, 0);
		for (int k = 0; k < 2000 && strb !== 1'b1; k++) @(posedge clk);
		chk(16'(strb), 16'h0001);
		u_m.frame(8'h00, 16, 8'h00, 0);
		chk(16'(rx[15:2]), 16'(res));
		chk(16'(conv), 16'(e));
	endtask
	task automatic modeb(input logic [2:0] m, input logic [2:0] e);
		u_m.frame({1'b1, m, asc_pkg::MODE_TAIL}, 8, 8'h00, 0);
		chk(16'(mode), 16'(e));
	endtask
	initial begin
		logic [2:0] r3;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(16'({mode, oe, strb, conv}), 16'h0000);
		for (int r = 1; r < 8; r++) begin
			u_m.frame({4'hB, 1'b0, 3'(r)}, 8, 8'h00, 0);
			start0(expc(3'h3, 1'b0, 3'(r)));
		end
		for (int i = 0; i < 4; i++) begin
			r3 = (i == 3) ? 3'h2 : 3'(1 + 3 * i);
			u_m.frame({4'hA, 1'b1, r3}, 8, 8'h00, 0);
			start0(expc(3'h2, 1'b1, (i == 3) ? 3'h7 : r3));
		end
		start0(expc(3'h5, 1'b0, 3'h7));
		// Start bit while B0 stands is taken; one while B7..B4 stand is refused
		u_m.frame({1'b1, 3'h3, 4'h0}, 55, {1'b1, 3'h5, 4'h0}, 27);
		chk(16'(conv), 16'(expc(3'h5, 1'b0, 3'h7)));
		chk(16'(rx[13:0]), 16'(res));
		u_m.frame({1'b1, 3'h3, 4'h0}, 28, 8'hD0, 20);
		chk(16'(conv), 16'(expc(3'h3, 1'b0, 3'h7)));
		chk(16'(rx[13:0]), 16'(res));
		res <= 14'h13A5;
		modeb(3'h1, 3'h1);
		convi(16, expc(3'h3, 1'b0, 3'h7));
		modeb(3'h2, 3'h2);
		convi(8, expc(3'h2, 1'b1, 3'h7));
		modeb(3'h3, 3'h2);
		modeb(3'h6, 3'h6);
		u_m.frame(8'hD0, 8, 8'h00, 0);
		chk(16'(conv), 16'(expc(3'h2, 1'b1, 3'h7)));
		modeb(3'h7, 3'h7);
		modeb(3'h4, 3'h0);
		start0(expc(3'h2, 1'b0, 3'h7));
		stop_test();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		stop_test();
	end
endmodule // test_asc_top
